//--- rtl/mtci_regs.svh
// Register offsets, field positions, reset values and timing counts of the
// multichannel transmit, command and interrupt queue block.
// Assumes a 12-bit APB byte address and 32-bit data words.
`ifndef MTCI_REGS_SVH
`define MTCI_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define MTCI_OFS_CMD        12'h000
`define MTCI_OFS_QBASE      12'h004
`define MTCI_OFS_QPTR       12'h008
`define MTCI_OFS_SEVT       12'h00C
`define MTCI_WIN_PAGE       4'h1
`define MTCI_CH_SUB_MODE    2'h0
`define MTCI_CH_SUB_TX_INTERNAL_STATE  2'h1
`define MTCI_CH_SUB_MASK    2'h2
`define MTCI_CH_SUB_STATUS  2'h3
`define MTCI_CH_FIRST       4'h1
`define MTCI_CH_LAST        4'h4

// ==========================================================================
// Command register fields
`define MTCI_CMD_FLAG       0
`define MTCI_CMD_CH_LSB     2
`define MTCI_CMD_CH_MSB     7
`define MTCI_CMD_OP_LSB     8
`define MTCI_CMD_OP_MSB     10
`define MTCI_OP_STOP_TX     3'h1

// ==========================================================================
// Transmit internal state word fields
`define MTCI_TS_ZERO_HI     31
`define MTCI_TS_ZERO_LO     30
`define MTCI_TS_ONE         29
`define MTCI_TS_BIG_ENDIAN  28
`define MTCI_TS_CODE_MSB    27
`define MTCI_TS_CODE_LSB    24
`define MTCI_TS_AT_MSB      26
`define MTCI_TS_RESET       32'h2000_0000

// ==========================================================================
// Channel mode register fields
`define MTCI_MODE_ENT       0
`define MTCI_MODE_POL       1
`define MTCI_MODE_IDLE_MODE_SELECT      2

// ==========================================================================
// Interrupt queue entry, mask and serial event fields
`define MTCI_ENT_VALID      15
`define MTCI_ENT_WRAP       14
`define MTCI_ENT_CH_MSB     9
`define MTCI_ENT_CH_LSB     6
`define MTCI_EVENT_FIELD    16'h303F
`define MTCI_QPTR_RESET     6'h00

// ==========================================================================
// Line patterns and timing
`define MTCI_PAT_ABORT      8'h7F
`define MTCI_PAT_FLAG       8'h7E
`define MTCI_PAT_IDLE       8'hFF
`define MTCI_TICK_DIV       4'h8

`endif

//--- rtl/mtci_pkg.sv
// Types shared by the transmit, command and interrupt queue block.
// Assumes four channels and a 64-entry interrupt queue.
package mtci_pkg;

	// ======================================================================
	// Interrupt queue writer states
	typedef enum logic [3:0] {
		Q_IDLE  = 4'b0001,
		Q_READ  = 4'b0010,
		Q_WRITE = 4'b0100,
		Q_EVENT = 4'b1000
	} mtci_qstate_t;

	// ======================================================================
	// Carriers
	typedef struct packed {
		logic        valid;
		logic [1:0]  channel;
		logic [15:0] bits;
	} mtci_event_t;

	typedef struct packed {
		logic        req;
		logic [1:0]  channel;
		logic        big_endian;
		logic [3:0]  code;
		logic [15:0] pointer;
	} mtci_fetch_t;

	typedef struct packed {
		logic        have;
		logic        last;
		logic [7:0]  data;
	} mtci_src_t;

	typedef struct packed {
		logic        valid;
		logic [1:0]  channel;
		logic [7:0]  data;
	} mtci_txbyte_t;

endpackage

//--- rtl/mtci_queue_mem.sv
// Interrupt queue storage: 64 words of 16 bits, one port, registered read.
// Assumes a single owner of the port in any cycle.
`timescale 1ns/100ps
module mtci_queue_mem (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        we,
	input  wire logic [5:0]  addr,
	input  wire logic [15:0] wdata,
	output logic      [15:0] rdata
);

	logic [15:0] mem [0:63];

	// Write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// Registered read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= mem[addr];
		end
	end

endmodule

//--- rtl/mtci_top.sv
// Multichannel transmit engine: state words, host command, interrupt queue.
// Assumes an APB master, a byte source answering fetches in the same cycle,
// and an event source holding each event until it is accepted.
//
// Behaviour
// - High byte bits 0-1 of the transmit state read zero, bit 2 reads one.
// - State bit 3 picks fetch byte order: zero little-endian, one big-endian.
// - Function-code variant: state bits 4-7 go with every transmit fetch.
// - Address-type variant: bit 4 forced zero, bits 5-7 carry address type.
// - Stop command 001 halts the channel and clears its polling bit.
// - Stop mid-frame sends abort 7F, then idles or flags per idle mode.
// - Stop between frames keeps sending idles or flags per idle mode.
// - Stop leaves the transmit descriptor pointer unchanged.
// - Polling bit set by host starts or resumes channel transmission.
// - Event writes entry with channel and type, sets valid, bumps pointer.
// - Pointer reloads from base after the entry carrying the wrap bit.
// - Only events enabled in the channel mask produce a queue entry.
// - After each queue write the serial event register gains the event bits.
// - Entry holds valid 0, wrap 1, events and channel at their positions.
// - Mask zero blocks an event, one enables it; reserved mask bits zero.
`timescale 1ns/100ps
`include "mtci_regs.svh"
module mtci_top #(
	parameter bit FC_VARIANT = 1'b1
) (
	input  wire logic                  CLOCK,
	input  wire logic                  RESETN,
	input  wire logic                  PSEL,
	input  wire logic                  PENABLE,
	input  wire logic                  PWRITE,
	input  wire logic [11:0]           PADDR,
	input  wire logic [31:0]           PWDATA,
	output logic      [31:0]           PRDATA,
	output logic                       PREADY,
	output logic                       PSLVERR,
	input  wire mtci_pkg::mtci_event_t EVENT_IN,
	output logic                       EVENT_READY,
	output mtci_pkg::mtci_fetch_t      FETCH_OUT,
	input  wire mtci_pkg::mtci_src_t   FETCH_IN,
	output mtci_pkg::mtci_txbyte_t     TX_OUT
);

	// ======================================================================
	// Declarations
	logic [15:0]            cmd;
	logic [3:0]             tx_enable_bit;
	logic [3:0]             tx_polling_bit;
	logic [3:0]             idle_mode_select;
	logic [3:0]             in_frame;
	logic [3:0]             abort_pend;
	logic [31:0]            tx_internal_state [0:3];
	logic [15:0]            evmask [0:3];
	logic [15:0]            txptr  [0:3];
	logic [5:0]             qbase;
	logic [5:0]             qptr;
	logic [15:0]            sevt;
	mtci_pkg::mtci_qstate_t qstate;
	logic [1:0]             ev_ch;
	logic [15:0]            ev_bits;
	logic                   ack;
	logic                   mem_wait;
	logic [31:0]            rd_mux;
	logic [3:0]             tick_cnt;
	logic                   tick;
	logic                   tick_d;
	logic [1:0]             rr_ch;
	logic                   acc;
	logic                   is_win;
	logic                   is_ch;
	logic [1:0]             ch_idx;
	logic                   mapped;
	logic                   wr;
	logic [3:0]             stop_hit;
	logic [3:0]             sent;
	logic [15:0]            masked;
	logic                   q_we;
	logic [5:0]             q_addr;
	logic [15:0]            q_wdata;
	logic [15:0]            q_rdata;
	logic [15:0]            entry;

	// Keep fixed bits and, for the address-type part, clear bit 4
	function automatic logic [31:0] ts_fix(input logic [31:0] v);
		logic [31:0] r;
		r = v;
		r[`MTCI_TS_ZERO_HI] = 1'b0;
		r[`MTCI_TS_ZERO_LO] = 1'b0;
		r[`MTCI_TS_ONE]     = 1'b1;
		if (!FC_VARIANT) begin
			r[`MTCI_TS_CODE_MSB] = 1'b0;
		end
		return r;
	endfunction

	// ======================================================================
	// APB decode
	assign acc    = PSEL & PENABLE;
	assign is_win = (PADDR[11:8] == `MTCI_WIN_PAGE);
	assign is_ch  = (PADDR[11:8] == 4'h0) && (PADDR[7:4] >= `MTCI_CH_FIRST)
	                && (PADDR[7:4] <= `MTCI_CH_LAST);
	assign ch_idx = 2'(PADDR[5:4] - 2'h1);
	assign mapped = (PADDR[1:0] == 2'h0) && (is_win || is_ch
	                || PADDR == `MTCI_OFS_CMD || PADDR == `MTCI_OFS_QBASE
	                || PADDR == `MTCI_OFS_QPTR || PADDR == `MTCI_OFS_SEVT);
	assign wr      = acc & ack & PWRITE & mapped;
	assign PREADY  = acc & ack;
	assign PSLVERR = acc & ack & !mapped;

	// Access phase acknowledge; the queue window waits for its read word
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ack <= 1'b0;
		end else if (ack) begin
			ack <= 1'b0;
		end else if (acc && (!(is_win && mapped) || mem_wait)) begin
			ack <= 1'b1;
		end
	end

	// Queue window read issued while the queue writer is idle
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			mem_wait <= 1'b0;
		end else if (ack) begin
			mem_wait <= 1'b0;
		end else if (acc && is_win && mapped && qstate == mtci_pkg::Q_IDLE) begin
			mem_wait <= 1'b1;
		end
	end

	// Read multiplexer over the register file
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (PADDR == `MTCI_OFS_CMD) begin
			rd_mux = 32'(cmd);
		end else if (PADDR == `MTCI_OFS_QBASE) begin
			rd_mux = 32'(qbase);
		end else if (PADDR == `MTCI_OFS_QPTR) begin
			rd_mux = 32'(qptr);
		end else if (PADDR == `MTCI_OFS_SEVT) begin
			rd_mux = 32'(sevt);
		end else if (is_ch) begin
			case (PADDR[3:2])
				`MTCI_CH_SUB_MODE: begin
					rd_mux = 32'({idle_mode_select[ch_idx], tx_polling_bit[ch_idx], tx_enable_bit[ch_idx]});
				end
				`MTCI_CH_SUB_TX_INTERNAL_STATE: begin
					rd_mux = tx_internal_state[ch_idx];
				end
				`MTCI_CH_SUB_MASK: begin
					rd_mux = 32'(evmask[ch_idx]);
				end
				default: begin
					rd_mux = 32'({abort_pend[ch_idx], in_frame[ch_idx], txptr[ch_idx]});
				end
			endcase
		end
	end

	// Read data register
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			PRDATA <= 32'h0000_0000;
		end else if (acc && !ack && !PWRITE) begin
			if (is_win && mapped) begin
				PRDATA <= 32'(q_rdata);
			end else if (mapped) begin
				PRDATA <= rd_mux;
			end else begin
				PRDATA <= 32'h0000_0000;
			end
		end
	end

	// ======================================================================
	// Host command register
	// operations arrive only as command register writes
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			cmd <= 16'h0000;
		end else if (wr && PADDR == `MTCI_OFS_CMD) begin
			cmd <= PWDATA[15:0];
		end else if (cmd[`MTCI_CMD_FLAG]) begin
			cmd[`MTCI_CMD_FLAG] <= 1'b0;
		end
	end

	// Stop command decode, one cycle after the write
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			stop_hit[c] = cmd[`MTCI_CMD_FLAG]
			              && cmd[`MTCI_CMD_OP_MSB:`MTCI_CMD_OP_LSB] == `MTCI_OP_STOP_TX
			              && cmd[`MTCI_CMD_CH_MSB:`MTCI_CMD_CH_LSB] == 6'(c);
			sent[c]     = FETCH_OUT.req && FETCH_OUT.channel == 2'(c) && FETCH_IN.have;
		end
	end

	// ======================================================================
	// Per-channel configuration and frame state
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			tx_enable_bit        <= 4'h0;
			tx_polling_bit        <= 4'h0;
			idle_mode_select       <= 4'h0;
			in_frame   <= 4'h0;
			abort_pend <= 4'h0;
			for (int c = 0; c < 4; c++) begin
				tx_internal_state[c] <= `MTCI_TS_RESET;
				evmask[c] <= 16'h0000;
				txptr[c]  <= 16'h0000;
			end
		end else begin
			for (int c = 0; c < 4; c++) begin
				if (wr && is_ch && ch_idx == 2'(c)) begin
					case (PADDR[3:2])
						`MTCI_CH_SUB_MODE: begin
							// host sets polling bit to start or resume
							tx_enable_bit[c]  <= PWDATA[`MTCI_MODE_ENT];
							tx_polling_bit[c]  <= PWDATA[`MTCI_MODE_POL];
							idle_mode_select[c] <= PWDATA[`MTCI_MODE_IDLE_MODE_SELECT];
						end
						`MTCI_CH_SUB_TX_INTERNAL_STATE: begin
							tx_internal_state[c] <= ts_fix(PWDATA);
						end
						`MTCI_CH_SUB_MASK: begin
							evmask[c] <= PWDATA[15:0] & `MTCI_EVENT_FIELD;
						end
						default: begin
						end
					endcase
				end
				// Frame tracking from bytes taken from the source
				if (sent[c]) begin
					in_frame[c] <= !FETCH_IN.last;
					if (FETCH_IN.last) begin
						txptr[c] <= 16'(txptr[c] + 16'h0001);
					end
				end
				// Abort goes out on the channel's next slot
				if (TX_OUT.valid && TX_OUT.channel == 2'(c)
				    && TX_OUT.data == `MTCI_PAT_ABORT && abort_pend[c]) begin
					abort_pend[c] <= 1'b0;
				end
				if (stop_hit[c]) begin
					tx_polling_bit[c]        <= 1'b0;
					abort_pend[c] <= in_frame[c] | (sent[c] & !FETCH_IN.last);
					in_frame[c]   <= 1'b0;
				end
			end
		end
	end

	// ======================================================================
	// Byte slot divider and round-robin channel
	assign tick = (tick_cnt == 4'(`MTCI_TICK_DIV - 4'h1));

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			tick_cnt <= 4'h0;
			tick_d   <= 1'b0;
			rr_ch    <= 2'h0;
		end else begin
			tick_cnt <= tick ? 4'h0 : 4'(tick_cnt + 4'h1);
			tick_d   <= tick;
			if (tick) begin
				rr_ch <= 2'(rr_ch + 2'h1);
			end
		end
	end

	// Fetch request for the slot's channel while it is active
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			FETCH_OUT <= '0;
		end else if (tick) begin
			FETCH_OUT.req        <= tx_enable_bit[rr_ch] & tx_polling_bit[rr_ch] & !stop_hit[rr_ch];
			FETCH_OUT.channel    <= rr_ch;
			FETCH_OUT.big_endian <= tx_internal_state[rr_ch][`MTCI_TS_BIG_ENDIAN];
			FETCH_OUT.code       <= FC_VARIANT ?
			                        tx_internal_state[rr_ch][`MTCI_TS_CODE_MSB:`MTCI_TS_CODE_LSB] :
			                        {1'b0, tx_internal_state[rr_ch][`MTCI_TS_AT_MSB:`MTCI_TS_CODE_LSB]};
			FETCH_OUT.pointer    <= txptr[rr_ch];
		end else begin
			FETCH_OUT.req <= 1'b0;
		end
	end

	// Line byte for the slot: data, abort, or idle fill
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			TX_OUT <= '0;
		end else begin
			TX_OUT.valid <= tick_d;
			if (tick_d) begin
				TX_OUT.channel <= FETCH_OUT.channel;
				if (sent[FETCH_OUT.channel]) begin
					TX_OUT.data <= FETCH_IN.data;
				end else if (abort_pend[FETCH_OUT.channel]) begin
					TX_OUT.data <= `MTCI_PAT_ABORT;
				end else if (idle_mode_select[FETCH_OUT.channel]) begin
					TX_OUT.data <= `MTCI_PAT_FLAG;
				end else begin
					TX_OUT.data <= `MTCI_PAT_IDLE;
				end
			end
		end
	end

	// ======================================================================
	// Interrupt queue writer
	// masked events leave no entry
	assign masked      = EVENT_IN.bits & evmask[EVENT_IN.channel] & `MTCI_EVENT_FIELD;
	assign EVENT_READY = (qstate == mtci_pkg::Q_IDLE) && !(PSEL && is_win);

	// entry layout with wrap bit kept from memory
	always_comb begin
		entry = ev_bits;
		entry[`MTCI_ENT_VALID] = 1'b1;
		entry[`MTCI_ENT_WRAP]  = q_rdata[`MTCI_ENT_WRAP];
		entry[`MTCI_ENT_CH_MSB:`MTCI_ENT_CH_LSB] = 4'(ev_ch);
	end

	// Queue state machine
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			qstate  <= mtci_pkg::Q_IDLE;
			ev_ch   <= 2'h0;
			ev_bits <= 16'h0000;
		end else begin
			case (qstate)
				mtci_pkg::Q_IDLE: begin
					if (EVENT_IN.valid && EVENT_READY && masked != 16'h0000) begin
						ev_ch   <= EVENT_IN.channel;
						ev_bits <= masked;
						qstate  <= mtci_pkg::Q_READ;
					end
				end
				mtci_pkg::Q_READ: begin
					qstate <= mtci_pkg::Q_WRITE;
				end
				mtci_pkg::Q_WRITE: begin
					qstate <= mtci_pkg::Q_EVENT;
				end
				mtci_pkg::Q_EVENT: begin
					qstate <= mtci_pkg::Q_IDLE;
				end
				default: begin
					qstate <= mtci_pkg::Q_IDLE;
				end
			endcase
		end
	end

	// Queue base and current pointer
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			qbase <= `MTCI_QPTR_RESET;
			qptr  <= `MTCI_QPTR_RESET;
		end else begin
			if (wr && PADDR == `MTCI_OFS_QBASE) begin
				qbase <= PWDATA[5:0];
			end
			if (wr && PADDR == `MTCI_OFS_QPTR) begin
				qptr <= PWDATA[5:0];
			end
			if (qstate == mtci_pkg::Q_WRITE) begin
				if (q_rdata[`MTCI_ENT_WRAP]) begin
					qptr <= qbase;
				end else begin
					qptr <= 6'(qptr + 6'h01);
				end
			end
		end
	end

	// Serial event register, write one to clear, set wins
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			sevt <= 16'h0000;
		end else begin
			sevt <= (sevt & ~((wr && PADDR == `MTCI_OFS_SEVT) ? PWDATA[15:0] : 16'h0000))
			        | ((qstate == mtci_pkg::Q_EVENT) ? ev_bits : 16'h0000);
		end
	end

	// Memory port: writer owns it outside idle, the bus otherwise
	assign q_addr  = (qstate != mtci_pkg::Q_IDLE) ? qptr : PADDR[7:2];
	assign q_we    = (qstate == mtci_pkg::Q_WRITE) || (wr && is_win);
	assign q_wdata = (qstate == mtci_pkg::Q_WRITE) ? entry : PWDATA[15:0];

	mtci_queue_mem u_mem (
		.clk    (CLOCK),
		.resetn (RESETN),
		.we     (q_we),
		.addr   (q_addr),
		.wdata  (q_wdata),
		.rdata  (q_rdata)
	);

endmodule

//--- bench/mtci_monitor.sv
// Checker for the transmit block: fetch fields, byte stream, stop, queue.
// Assumes it is bound to mtci_top and that the APB master holds each request.
`timescale 1ns/100ps
module mtci_monitor #(
	parameter bit FC_VARIANT = 1'b1
) (
	input wire logic                   CLOCK,
	input wire logic                   RESETN,
	input wire logic                   PSEL,
	input wire logic                   PENABLE,
	input wire logic                   PWRITE,
	input wire logic [11:0]            PADDR,
	input wire logic [31:0]            PWDATA,
	input wire logic [31:0]            PRDATA,
	input wire logic                   PREADY,
	input wire logic                   PSLVERR,
	input wire mtci_pkg::mtci_event_t  EVENT_IN,
	input wire logic                   EVENT_READY,
	input wire mtci_pkg::mtci_fetch_t  FETCH_OUT,
	input wire mtci_pkg::mtci_src_t    FETCH_IN,
	input wire mtci_pkg::mtci_txbyte_t TX_OUT
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RESETN);
	// ==================================================================
	// Shadow copies of state word order and code bits, masks and the last stop command
	logic [4:0]  ts [4];
	logic [15:0] msk [4];
	logic [1:0]  ch_w;
	logic [1:0]  stop_ch;
	logic [5:0]  stop_cnt;
	logic        wr;
	logic        stop_wr;
	logic        ev_take;
	logic        ev_hit;
	assign wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
	assign stop_wr = wr && PADDR == 12'h000 && PWDATA[10:8] == 3'h1 && PWDATA[7:4] == 4'h0
	                 && PWDATA[0];
	assign ch_w = 2'(PADDR[7:4] - 4'h1);
	assign ev_take = EVENT_IN.valid && EVENT_READY;
	assign ev_hit = ev_take && (EVENT_IN.bits & msk[EVENT_IN.channel] & 16'h303F) != 16'h0000;
	// Track host writes to state words and masks
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ts <= '{default: 5'h00};
			msk <= '{default: 16'h0000};
		end else if (wr && PADDR[11:8] == 4'h0 && PADDR[7:4] inside {[4'h1:4'h4]}) begin
			if (PADDR[3:0] == 4'h4)
				ts[ch_w] <= PWDATA[28:24];
			if (PADDR[3:0] == 4'h8)
				msk[ch_w] <= PWDATA[15:0];
		end
	end
	// Count the window after a stop in which the channel must stay quiet
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			stop_ch <= 2'h0;
			stop_cnt <= 6'h00;
		end else if (stop_wr) begin
			stop_ch <= PWDATA[3:2];
			stop_cnt <= 6'h28;
		end else if (stop_cnt != 6'h00) begin
			stop_cnt <= stop_cnt - 6'h01;
		end
	end
	// ==================================================================
	// fetch byte order and function code
	fetch_order_a: assert property (FETCH_OUT.req |-> FETCH_OUT.big_endian == ts[FETCH_OUT.channel][4])
		else $error("fetch byte order differs from state word");
	fetch_code_a: assert property (FETCH_OUT.req |-> FETCH_OUT.code ==
		(FC_VARIANT ? ts[FETCH_OUT.channel][3:0] : {1'b0, ts[FETCH_OUT.channel][2:0]}))
		else $error("fetch code differs from state word");
	// fetched byte goes out next cycle
	tx_follow_a: assert property (FETCH_OUT.req |=> TX_OUT.valid &&
		TX_OUT.channel == $past(FETCH_OUT.channel) &&
		(!$past(FETCH_IN.have) || TX_OUT.data == $past(FETCH_IN.data)))
		else $error("sent byte does not follow its fetch");
	tx_pace_a: assert property (TX_OUT.valid |=> !TX_OUT.valid [*7] ##1 TX_OUT.valid)
		else $error("byte slots not every eight cycles");
	stop_halt_a: assert property (!(FETCH_OUT.req && FETCH_OUT.channel == stop_ch &&
		stop_cnt != 6'h00 && stop_cnt < 6'h28))
		else $error("fetch on a stopped channel");
	event_busy_a: assert property (ev_hit |=> !EVENT_READY [*3])
		else $error("queue writer not busy after event");
	event_drop_a: assert property (ev_take && !ev_hit |=> EVENT_READY || PSEL)
		else $error("masked event occupied the writer");
	apb_answer_a: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |-> ##[0:7] PREADY)
		else $error("register access not answered");
	cover property (stop_wr);
	cover property (ev_hit);
	cover property (FETCH_OUT.req && FETCH_IN.last);
endmodule

bind mtci_top mtci_monitor #(.FC_VARIANT(FC_VARIANT)) u_monitor (
	.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.EVENT_IN(EVENT_IN), .EVENT_READY(EVENT_READY), .FETCH_OUT(FETCH_OUT),
	.FETCH_IN(FETCH_IN), .TX_OUT(TX_OUT)
);

//--- bench/mtci_src_model.sv
// Byte source model: transmit buffer memory behind the fetch port.
// Assumes fetches are answered in the request cycle; frames end per byte or never.
`timescale 1ns/100ps
module mtci_src_model (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  end_each,
	input  wire mtci_pkg::mtci_fetch_t fetch,
	output mtci_pkg::mtci_src_t        src
);
	logic [7:0] count;
	// each fetch takes the next buffer byte
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			count <= 8'h10;
		else if (fetch.req)
			count <= count + 8'h01;
	end
	// Outside a fetch the data lines show the inverse, never a stale byte
	assign src = '{have: fetch.req, last: fetch.req && end_each, data: fetch.req ? count : ~count};
endmodule

//--- bench/multichannel_tx_cmd_int_queue_test.sv
// Testbench: register bus, transmit stop, interrupt queue of mtci_top.
// Assumes the byte source model and the bound checker beside the design.
`timescale 1ns/100ps
module multichannel_tx_cmd_int_queue_test;
	logic                   clock;
	logic                   resetn;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [11:0]            paddr;
	logic [31:0]            pwdata;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   ev_ready;
	logic                   end_each;
	logic [31:0]            q;
	logic                   e;
	mtci_pkg::mtci_event_t  ev;
	mtci_pkg::mtci_fetch_t  fetch;
	mtci_pkg::mtci_src_t    src;
	mtci_pkg::mtci_txbyte_t tx;
	int                     err_total;
	int                     total_checks;
	mtci_top #(.FC_VARIANT(1'b1)) dut (
		.CLOCK(clock), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EVENT_IN(ev), .EVENT_READY(ev_ready), .FETCH_OUT(fetch), .FETCH_IN(src), .TX_OUT(tx)
	);
	mtci_src_model partner (.clk(clock), .resetn(resetn), .end_each(end_each), .fetch(fetch), .src(src));
	// Clock at 50 MHz
	always #10 clock = ~clock;
	// ==================================================================
	// Checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic hang;
		err_total++;
		end_sim();
	endtask
	// ==================================================================
	// APB transfer, held until PREADY is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		// Ready, data and error are all taken at the rising edge
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			hang();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFF_FFFF);
		apb(1'b0, a, 32'h0000_0000);
		chk(q & m, x);
	endtask
	// Wait for the next line byte of a channel and compare it
	task automatic tx_chk(input logic [1:0] ch, input logic [7:0] x);
		int n;
		n = 0;
		@(negedge clock);
		while (!(tx.valid === 1'b1 && tx.channel === ch) && n < 300) begin
			@(negedge clock);
			n++;
		end
		if (n == 300)
			hang();
		chk({24'h00_0000, tx.data}, {24'h00_0000, x});
	endtask
	// Offer one event and hold it until the writer takes it
	task automatic ev_send(input logic [1:0] ch, input logic [15:0] b);
		int n;
		@(posedge clock);
		ev <= '{1'b1, ch, b};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ev_ready !== 1'b1 && n < 20);
		if (ev_ready !== 1'b1)
			hang();
		ev <= '{1'b0, ~ch, ~b};
		repeat (5) @(posedge clock);
	endtask
	// ==================================================================
	// Main sequence
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ev = '0;
		end_each = 1'b1;
		err_total = 0;
		total_checks = 0;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		// fixed bits, function code 8 big-endian
		rd_chk(12'h014, 32'h2000_0000);
		apb(1'b1, 12'h014, 32'hC000_0000);
		rd_chk(12'h014, 32'h2000_0000);
		apb(1'b1, 12'h014, 32'h3800_0000);
		rd_chk(12'h014, 32'h3800_0000);
		apb(1'b0, 12'h204, 32'h0000_0000);
		chk({q[30:0], e}, 32'h0000_0001);
		tx_chk(2'h0, 8'hFF);
		apb(1'b1, 12'h010, 32'h0000_0003);
		tx_chk(2'h0, 8'h10);
		tx_chk(2'h0, 8'h11);
		rd_chk(12'h01C, 32'h0000_0002, 32'h0003_FFFF);
		apb(1'b1, 12'h000, 32'h0000_0101);
		rd_chk(12'h000, 32'h0000_0000, 32'h0000_0001);
		tx_chk(2'h0, 8'hFF);
		tx_chk(2'h0, 8'hFF);
		apb(1'b1, 12'h010, 32'h0000_0007);
		end_each <= 1'b0;
		// stop in mid-frame sends abort then flags
		tx_chk(2'h0, 8'h12);
		apb(1'b1, 12'h000, 32'h0000_0101);
		tx_chk(2'h0, 8'h7F);
		tx_chk(2'h0, 8'h7E);
		rd_chk(12'h01C, 32'h0000_0002, 32'h0000_FFFF);
		rd_chk(12'h010, 32'h0000_0005);
		apb(1'b1, 12'h010, 32'h0000_0006);
		tx_chk(2'h0, 8'h7E);
		apb(1'b1, 12'h014, 32'h3800_0000);
		apb(1'b1, 12'h010, 32'h0000_0007);
		tx_chk(2'h0, 8'h13);
		// queue entries, wrap, mask, event register
		apb(1'b1, 12'h004, 32'h0000_0002);
		apb(1'b1, 12'h008, 32'h0000_0002);
		apb(1'b1, 12'h108, 32'h0000_0000);
		apb(1'b1, 12'h10C, 32'h0000_4000);
		apb(1'b1, 12'h028, 32'h0000_0003);
		ev_send(2'h1, 16'h0002);
		rd_chk(12'h008, 32'h0000_0003);
		ev_send(2'h1, 16'h2000);
		ev_send(2'h2, 16'h0001);
		rd_chk(12'h008, 32'h0000_0003);
		ev_send(2'h1, 16'h0001);
		rd_chk(12'h108, 32'h0000_8042);
		rd_chk(12'h10C, 32'h0000_C041);
		rd_chk(12'h008, 32'h0000_0002);
		rd_chk(12'h00C, 32'h0000_0003);
		apb(1'b1, 12'h00C, 32'h0000_0003);
		rd_chk(12'h00C, 32'h0000_0000);
		end_sim();
	end
endmodule
